//--- src/char_recognition_flow_control.sv
`timescale 1ns/1ns
// How it works
// - Each channel has three programmable match characters: resume, pause, wake.
// - A match sets recognition status and interrupt status and, at the same clock edge, starts enabled actions.
// - Reading the recognition status register clears its recognition event flags.
// - Reset loads resume 0x11, pause 0x13; matching always uses current register values.
// - Strip bit 7 set drops resume/pause characters from the receive queue.
// - Stripping works regardless of the flow-control mode field bits 3:2.
// - Recognised characters act whether stripped or not.
// - Recognised characters with an error flag are queued unless they overrun, even when stripping.
// - Mode field: 00 host, 01 auto transmit, 10 auto receive, 11 both.
// - Mode bits 3:2 reset to zero, disabling automatic flow control; host commands still act.
// - Mode bit 2 lets received resume/pause characters gate the transmitter.
// - Mode bit 3 sends pause once receive occupancy reaches 240.
// - Host pause command halts transmitter until reset or the 10110 resume command.
// - In host mode, received resume or transmitter re-enable does not restart it.
// - Repeated or opposite send commands are harmless; the later one replaces the earlier.
// - Auto transmit: received pause stops after current character; resume or reset restarts.
// - A reset restart discards the untransmitted transmit queue contents.
// - Auto transmit mode ignores transmitter commands.
// - A paused transmitter still lets its queue accept writes and report status.
// - Break zero characters are matched like received zero characters.
// - Flow characters causing overrun neither act nor enter the queue.
// - Auto receive sends resume once occupancy falls below 16.
// - Inserted flow characters wait for the current shift and precede queued data.
// - A fill request that clears before transmission starts is withdrawn.
module char_recognition_flow_control
  import flow_ctl_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int LEVEL_W = 9
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_char,
  input  wire logic                 rx_error,
  input  wire logic                 rxq_full,
  input  wire logic [LEVEL_W-1:0]   rxq_level,
  output      logic                 rxq_write,
  output      logic [7:0]           rxq_data,
  output      logic                 rxq_error,
  output      logic                 rx_overrun,
  output      logic                 tx_enable,
  output      logic                 tx_insert_valid,
  output      logic [7:0]           tx_insert_char,
  input  wire logic                 tx_insert_taken,
  output      logic                 txq_flush
);
  import flow_ctl_pkg::*;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]  mode_reg_zero;
  logic [7:0]  resume_char;
  logic [7:0]  pause_char;
  logic [7:0]  wake_char;
  logic [2:0]  recog_flags;
  logic        pause_sent;
  logic        tx_on;
  logic        tx_halted;
  send_t       cmd_send;
  logic        aw_held;
  logic        w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire         wr_go       = aw_held && w_held && !s_axi_bvalid;
  wire         rd_go       = s_axi_arvalid && s_axi_arready;
  wire         wr_lane     = wr_go && w_lane0;
  wire [7:0]   wbyte       = w_data[7:0];
  wire [4:0]   cmd_code    = wbyte[7:CMD_LSB];
  wire [7:0]   waddr       = 8'(aw_addr);
  wire [7:0]   raddr       = 8'(s_axi_araddr);
  wire         wr_mode     = wr_lane && (waddr == OFS_MODE_ZERO);
  wire         wr_cmd      = wr_lane && (waddr == OFS_COMMAND);
  wire         wr_resume   = wr_lane && (waddr == OFS_RESUME_CHAR);
  wire         wr_pause    = wr_lane && (waddr == OFS_PAUSE_CHAR);
  wire         wr_wake     = wr_lane && (waddr == OFS_WAKE_CHAR);
  wire         wr_mapped;
  wire         rd_mapped;
  wire [7:0]   rd_value;
  wire         rd_recog    = rd_go && (raddr == OFS_RECOG_STAT);

  assign wr_mapped = (waddr == OFS_MODE_ZERO) || (waddr == OFS_COMMAND) ||
                     (waddr == OFS_RECOG_STAT) || (waddr == OFS_INT_STAT) ||
                     (waddr == OFS_RESUME_CHAR) || (waddr == OFS_PAUSE_CHAR) ||
                     (waddr == OFS_WAKE_CHAR);
  assign rd_mapped = (raddr == OFS_MODE_ZERO) || (raddr == OFS_COMMAND) ||
                     (raddr == OFS_RECOG_STAT) || (raddr == OFS_INT_STAT) ||
                     (raddr == OFS_RESUME_CHAR) || (raddr == OFS_PAUSE_CHAR) ||
                     (raddr == OFS_WAKE_CHAR);

  wire [7:0] recog_view;
  wire [7:0] int_view;
  assign recog_view = {3'h0, tx_halted, pause_sent, recog_flags};
  assign int_view   = {3'h0, |recog_flags, 4'h0};

  // The command register reads as zero; commands are actions, not state.
  assign rd_value = (raddr == OFS_MODE_ZERO)   ? mode_reg_zero :
                    (raddr == OFS_RECOG_STAT)  ? recog_view :
                    (raddr == OFS_INT_STAT)    ? int_view :
                    (raddr == OFS_RESUME_CHAR) ? resume_char :
                    (raddr == OFS_PAUSE_CHAR)  ? pause_char :
                    (raddr == OFS_WAKE_CHAR)   ? wake_char : 8'h00;

  // ==========================================================================
  // Mode and command decode
  // ==========================================================================
  wire strip_on = mode_reg_zero[MODE_STRIP_BIT];
  wire auto_rx  = mode_reg_zero[MODE_AUTO_RX_BIT];
  wire auto_tx  = mode_reg_zero[MODE_AUTO_TX_BIT];
  wire host_md  = !auto_rx && !auto_tx;
  // Transmitter commands are refused while received characters gate the transmitter.
  wire cmd_ok   = wr_cmd && !auto_tx;
  // Soft reset is obeyed in every mode, since it is the only restart of an
  // auto transmit halt that does not need a resume character.
  wire soft_rst = wr_cmd && (cmd_code == CMD_SOFT_RESET);
  wire c_enable = cmd_ok && (cmd_code == CMD_TX_ENABLE);
  wire c_disabl = cmd_ok && (cmd_code == CMD_TX_DISABLE);
  wire c_halt   = cmd_ok && host_md && (cmd_code == CMD_TX_PAUSE);
  wire c_unhalt = cmd_ok && host_md && (cmd_code == CMD_TX_RESUME);
  wire c_s_res  = cmd_ok && !auto_rx && (cmd_code == CMD_SEND_RESUME);
  wire c_s_pau  = cmd_ok && !auto_rx && (cmd_code == CMD_SEND_PAUSE);
  wire c_kill   = cmd_ok && host_md && (cmd_code == CMD_KILL_SEND);

  // ==========================================================================
  // Recognition
  // ==========================================================================
  // Break zeros arrive on the same path as line characters, so they match alike.
  wire hit_res  = rx_valid && (rx_char == resume_char);
  wire hit_pau  = rx_valid && (rx_char == pause_char);
  // The wake character is only matched and flagged here; the receiver
  // enable that it drives belongs to the wake and doze logic outside.
  wire hit_wake = rx_valid && (rx_char == wake_char);
  wire room     = !rxq_full;
  // A character that overruns the queue is not recognised at all.
  wire ok_res   = hit_res && room;
  wire ok_pau   = hit_pau && room;
  wire ok_wake  = hit_wake && room;
  wire strip_it = strip_on && (hit_res || hit_pau) && !rx_error;
  wire queue_it = rx_valid && room && !strip_it;
  wire [2:0] hits;
  assign hits[STAT_RESUME_BIT] = ok_res;
  assign hits[STAT_PAUSE_BIT]  = ok_pau;
  assign hits[STAT_WAKE_BIT]   = ok_wake;

  // Flags are set independent of stripping; a new hit beats a read clear.
  wire [2:0] next_recog_flags = hits | (rd_recog ? 3'h0 : recog_flags);

  // ==========================================================================
  // Transmitter gating
  // ==========================================================================
  // In host mode only the resume command or a reset restarts; a received resume or a
  // disable/enable cycle leaves the halt in place.
  wire next_tx_halted = (c_halt || (auto_tx && ok_pau)) ? 1'b1 :
                        (c_unhalt || (auto_tx && ok_res)) ? 1'b0 :
                        tx_halted;
  wire next_tx_on     = c_enable ? 1'b1 : (c_disabl ? 1'b0 : tx_on);

  // ==========================================================================
  // Flow character insertion
  // ==========================================================================
  // One spare bit keeps the limit constants from wrapping at level widths of 7 bits and up.
  logic [LEVEL_W:0] level_x;
  assign level_x = {1'b0, rxq_level};
  wire at_high = level_x >= (LEVEL_W+1)'(FILL_HIGH);
  wire below_lo = level_x < (LEVEL_W+1)'(FILL_LOW);
  // The fill request is recomputed every cycle, so a condition that clears
  // before the transmitter loads the character withdraws it.
  wire send_t auto_req = (!auto_rx) ? SEND_NONE :
                         (at_high && !pause_sent) ? SEND_PAUSE :
                         (below_lo && pause_sent) ? SEND_RESUME :
                         SEND_NONE;
  wire send_t want     = (auto_req != SEND_NONE) ? auto_req : cmd_send;
  wire        taken    = tx_insert_valid && tx_insert_taken;
  wire        taken_p  = taken && (tx_insert_char == pause_char);

  // In auto receive the fill level owns the insert path, so host sends drop.
  send_t next_cmd_send;
  always_comb begin
    next_cmd_send = cmd_send;
    if (taken && (cmd_send != SEND_NONE) && (auto_req == SEND_NONE)) begin
      next_cmd_send = SEND_NONE;
    end
    if (c_s_res) begin
      next_cmd_send = SEND_RESUME;
    end else if (c_s_pau) begin
      next_cmd_send = SEND_PAUSE;
    end else if (c_kill || auto_rx) begin
      next_cmd_send = SEND_NONE;
    end
  end

  // Leaving auto receive forgets an outstanding pause, so no resume follows
  // it; software must send one by command if the far end still waits.
  wire next_pause_sent = !auto_rx ? 1'b0 :
                         taken ? taken_p : pause_sent;
  // The offer drops for one cycle after each take, because the request
  // state only catches up at that edge; without the gap the transmitter
  // could load the same flow character twice.
  wire next_ins_valid  = (want != SEND_NONE) && !taken && !soft_rst;
  wire [7:0] next_ins_char = (want == SEND_PAUSE) ? pause_char : resume_char;

  // ==========================================================================
  // Control state
  // ==========================================================================
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg_zero <= RST_MODE_ZERO;
      resume_char   <= RST_RESUME_CHAR;
      pause_char    <= RST_PAUSE_CHAR;
      wake_char     <= RST_WAKE_CHAR;
      recog_flags   <= 3'h0;
      pause_sent    <= 1'b0;
      tx_on         <= 1'b1;
      tx_halted     <= 1'b0;
      cmd_send      <= SEND_NONE;
    end else if (soft_rst) begin
      mode_reg_zero <= RST_MODE_ZERO;
      resume_char   <= RST_RESUME_CHAR;
      pause_char    <= RST_PAUSE_CHAR;
      wake_char     <= RST_WAKE_CHAR;
      recog_flags   <= 3'h0;
      pause_sent    <= 1'b0;
      tx_on         <= 1'b1;
      tx_halted     <= 1'b0;
      cmd_send      <= SEND_NONE;
    end else begin
      if (wr_mode) begin
        mode_reg_zero <= wbyte;
      end
      if (wr_resume) begin
        resume_char <= wbyte;
      end
      if (wr_pause) begin
        pause_char <= wbyte;
      end
      if (wr_wake) begin
        wake_char <= wbyte;
      end
      recog_flags <= next_recog_flags;
      pause_sent  <= next_pause_sent;
      tx_on       <= next_tx_on;
      tx_halted   <= next_tx_halted;
      cmd_send    <= next_cmd_send;
    end
  end

  // ==========================================================================
  // Data path outputs
  // ==========================================================================
  // The transmitter gate only blocks loading of the next character, so the
  // one already shifting finishes and the queue keeps taking writes.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxq_write       <= 1'b0;
      rxq_data        <= 8'h00;
      rxq_error       <= 1'b0;
      rx_overrun      <= 1'b0;
      tx_enable       <= 1'b1;
      tx_insert_valid <= 1'b0;
      tx_insert_char  <= 8'h00;
      txq_flush       <= 1'b1;
    end else begin
      rxq_write       <= queue_it;
      rxq_data        <= rx_char;
      rxq_error       <= rx_error;
      rx_overrun      <= rx_valid && !room;
      tx_enable       <= next_tx_on && !next_tx_halted && !soft_rst;
      tx_insert_valid <= next_ins_valid;
      tx_insert_char  <= next_ins_char;
      txq_flush       <= soft_rst;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  // Write address and data are held apart so either may come first; the
  // answer waits until both are in, which costs one cycle per write.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  wire next_awready = !(aw_held || (s_axi_awvalid && s_axi_awready)) && !s_axi_bvalid;
  wire next_wready  = !(w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= next_awready && !wr_go;
      s_axi_wready  <= next_wready && !wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_ERROR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data are captured at the address handshake, so a status read and
  // the clear that it causes see the same flags.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_value};
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_ERROR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- src/flow_ctl_pkg.sv
package flow_ctl_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite bus
  // ==========================================================================
  localparam logic [7:0] OFS_MODE_ZERO   = 8'h00;
  localparam logic [7:0] OFS_COMMAND     = 8'h04;
  localparam logic [7:0] OFS_RECOG_STAT  = 8'h08;
  localparam logic [7:0] OFS_INT_STAT    = 8'h0C;
  localparam logic [7:0] OFS_RESUME_CHAR = 8'h10;
  localparam logic [7:0] OFS_PAUSE_CHAR  = 8'h14;
  localparam logic [7:0] OFS_WAKE_CHAR   = 8'h18;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MODE_STRIP_BIT   = 7;
  localparam int MODE_AUTO_RX_BIT = 3;
  localparam int MODE_AUTO_TX_BIT = 2;
  localparam int CMD_LSB          = 3;
  localparam int STAT_RESUME_BIT  = 0;
  localparam int STAT_PAUSE_BIT   = 1;
  localparam int STAT_WAKE_BIT    = 2;
  localparam int STAT_SENT_BIT    = 3;
  localparam int STAT_HALT_BIT    = 4;
  localparam int INT_RECOG_BIT    = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_MODE_ZERO   = 8'h00;
  localparam logic [7:0] RST_RESUME_CHAR = 8'h11;
  localparam logic [7:0] RST_PAUSE_CHAR  = 8'h13;
  localparam logic [7:0] RST_WAKE_CHAR   = 8'h00;

  // ==========================================================================
  // Command codes in command bits 7:3
  // ==========================================================================
  localparam logic [4:0] CMD_SOFT_RESET  = 5'h01;
  localparam logic [4:0] CMD_TX_ENABLE   = 5'h02;
  localparam logic [4:0] CMD_TX_DISABLE  = 5'h03;
  localparam logic [4:0] CMD_KILL_SEND   = 5'h13;
  localparam logic [4:0] CMD_SEND_RESUME = 5'h14;
  localparam logic [4:0] CMD_SEND_PAUSE  = 5'h15;
  localparam logic [4:0] CMD_TX_RESUME   = 5'h16;
  localparam logic [4:0] CMD_TX_PAUSE    = 5'h17;

  // ==========================================================================
  // Receive queue fill limits and bus answers
  // ==========================================================================
  localparam int         FILL_HIGH  = 240;
  localparam int         FILL_LOW   = 16;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h2;

  typedef enum logic [1:0] {SEND_NONE, SEND_RESUME, SEND_PAUSE} send_t;

endpackage

//--- verif/char_recognition_flow_control_test.sv
`timescale 1ns/1ns
module char_recognition_flow_control_test;
  import flow_ctl_pkg::*;
  logic mclk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, rx_valid = 0, rx_error = 0, rxq_full = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxq_write;
  logic rxq_error, rx_overrun, tx_enable, tx_insert_valid, tx_insert_taken, txq_flush, w, e;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_char = 0, rxq_data, tx_insert_char, c;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  rxq_level = 0;
  logic [2:0]  dly = 0;
  int err_count = 0, tests_run = 0, seed = 64, flushes = 0;
  always #25 mclk = ~mclk;
  char_recognition_flow_control char_recognition_flow_control_inst (.mclk, .reset_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid,
    .rx_char, .rx_error, .rxq_full, .rxq_level, .rxq_write, .rxq_data, .rxq_error, .rx_overrun,
    .tx_enable, .tx_insert_valid, .tx_insert_char, .tx_insert_taken, .txq_flush);
  remote_link remote_link_inst (.mclk, .reset_n, .tx_insert_valid, .delay(dly),
    .tx_insert_taken);
  always @(posedge mclk) if (reset_n && txq_flush === 1'b1) flushes++;
  // ======
  // Tasks
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 0; wd = 0;
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", (a > OFS_WAKE_CHAR) ? RESP_ERROR : RESP_OKAY, s_axi_bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] r, output logic [31:0] v);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk("rresp", r, s_axi_rresp);
  endtask
  task automatic cmd(input logic [4:0] k);
    axw(OFS_COMMAND, {24'h0, k, 3'h0});
  endtask
  task automatic rxs(input logic [7:0] ch, input logic er, output logic wr);
    rx_valid <= 1; rx_char <= ch; rx_error <= er;
    @(posedge mclk);
    rx_valid <= 0;
    @(posedge mclk);
    wr = rxq_write;
  endtask
  task automatic waitins(input logic v);
    for (int n = 0; n < 50 && tx_insert_valid !== v; n++) @(posedge mclk);
    chk("tx_insert_valid", v, tx_insert_valid);
  endtask
  function automatic logic exp_q(input logic [7:0] ch, input logic er);
    return !(ch == RST_RESUME_CHAR || ch == RST_PAUSE_CHAR) || er;
  endfunction
  initial begin #2000000; err_count++; print_verdict; end
  // ======
  // Scenarios
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    axr(OFS_MODE_ZERO, RESP_OKAY, d); chk("mode", 0, d);
    axr(OFS_RESUME_CHAR, RESP_OKAY, d); chk("resume", 32'h11, d);
    axr(OFS_PAUSE_CHAR, RESP_OKAY, d); chk("pause", 32'h13, d);
    axr(8'h40, RESP_ERROR, d); chk("unmapped", 0, d);
    axw(8'h40, 32'h55); axr(OFS_MODE_ZERO, RESP_OKAY, d); chk("unmapped wr", 0, d);
    axw(OFS_MODE_ZERO, 32'h80);
    for (int i = 0; i < 24; i++) begin
      c = 8'($random(seed)); e = 1'($random(seed));
      if (i % 4 == 0) c = (i % 8) ? 8'h11 : 8'h13;
      rxs(c, e, w); chk("rxq_write", exp_q(c, e), w);
    end
    axr(OFS_RECOG_STAT, RESP_OKAY, d);
    rxs(8'h13, 0, w); chk("stripped", 0, w);
    axr(OFS_INT_STAT, RESP_OKAY, d); chk("int", 1, d[4]);
    axr(OFS_RECOG_STAT, RESP_OKAY, d); chk("recog", 2, d[2:0]);
    axr(OFS_RECOG_STAT, RESP_OKAY, d); chk("cleared", 0, d[2:0]);
    rxq_full <= 1;
    rxs(8'h13, 0, w); chk("overrun", 0, w);
    rxq_full <= 0;
    axr(OFS_RECOG_STAT, RESP_OKAY, d); chk("no flag", 0, d[1]);
    axw(OFS_MODE_ZERO, 32'h84);
    rxs(8'h13, 0, w); chk("strip auto", 0, w);
    chk("paused", 0, tx_enable);
    cmd(CMD_TX_ENABLE); chk("cmd ignored", 0, tx_enable);
    rxs(8'h11, 0, w); chk("restart", 1, tx_enable);
    axw(OFS_PAUSE_CHAR, 0);
    rxs(8'h00, 0, w); chk("break zero", 0, tx_enable);
    axr(OFS_RECOG_STAT, RESP_OKAY, d); chk("wake", 7, d[2:0]);
    rxs(8'h11, 0, w);
    axw(OFS_PAUSE_CHAR, 32'h13); axw(OFS_MODE_ZERO, 0);
    cmd(CMD_TX_PAUSE); chk("host halt", 0, tx_enable);
    rxs(8'h11, 0, w); cmd(CMD_TX_ENABLE); chk("still halted", 0, tx_enable);
    cmd(CMD_TX_RESUME); chk("released", 1, tx_enable);
    cmd(CMD_SEND_PAUSE); cmd(CMD_SEND_PAUSE); waitins(1);
    chk("send char", 32'h13, tx_insert_char); waitins(0);
    axw(OFS_MODE_ZERO, 32'h08);
    repeat (3) begin
      dly <= 3'($random(seed));
      rxq_level <= 9'd240; waitins(1); chk("auto pause", 32'h13, tx_insert_char);
      waitins(0); axr(OFS_RECOG_STAT, RESP_OKAY, d); chk("sent", 1, d[3]);
      rxq_level <= 9'd15; waitins(1); chk("auto resume", 32'h11, tx_insert_char);
      waitins(0);
    end
    axw(OFS_RESUME_CHAR, 32'h55); flushes = 0;
    cmd(CMD_SOFT_RESET); @(posedge mclk); chk("flush", 1, flushes);
    axr(OFS_RESUME_CHAR, RESP_OKAY, d); chk("soft reset", 32'h11, d);
    print_verdict;
  end
endmodule

//--- verif/flow_ctl_asserts.sv
`timescale 1ns/1ns
module flow_ctl_asserts
  import flow_ctl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_char,
  input wire logic        rx_error,
  input wire logic        rxq_full,
  input wire logic        rxq_write,
  input wire logic [7:0]  rxq_data,
  input wire logic        rxq_error,
  input wire logic        rx_overrun,
  input wire logic        tx_enable,
  input wire logic        tx_insert_valid,
  input wire logic        tx_insert_taken,
  input wire logic        txq_flush
);
  // ======
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_overrun_flag: assert property (rx_valid && rxq_full |=> rx_overrun && !rxq_write)
    else $error("overrun not flagged");
  a_no_overrun: assert property (rx_valid && !rxq_full |=> !rx_overrun)
    else $error("false overrun");
  a_error_kept: assert property (rx_valid && rx_error && !rxq_full |=>
    rxq_write && rxq_error && rxq_data == $past(rx_char)) else $error("error char lost");
  a_write_cause: assert property (rxq_write |-> $past(rx_valid) && !$past(rxq_full))
    else $error("queue write without a char");
  a_flush_pulse: assert property (txq_flush |=> !txq_flush)
    else $error("flush longer than one cycle");
  a_flush_halt: assert property (txq_flush && !$past(txq_flush) |-> !tx_enable)
    else $error("transmitter runs during flush");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_insert_once: assert property (tx_insert_valid && tx_insert_taken |=> !tx_insert_valid)
    else $error("flow char offered again after take");
endmodule
bind char_recognition_flow_control flow_ctl_asserts flow_ctl_asserts_inst (.mclk, .reset_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .rx_valid, .rx_char, .rx_error, .rxq_full, .rxq_write,
  .rxq_data, .rxq_error, .rx_overrun, .tx_enable, .txq_flush, .tx_insert_valid,
  .tx_insert_taken);

//--- verif/remote_link.sv
`timescale 1ns/1ns
module remote_link (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       tx_insert_valid,
  input  wire logic [2:0] delay,
  output      logic       tx_insert_taken
);
  // ======
  // Shifter load
  logic [2:0] cnt;
  wire        wait_load = tx_insert_valid && !tx_insert_taken;
  // The shifter only loads while a character is offered, after a settable wait.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt             <= 3'h0;
      tx_insert_taken <= 1'b0;
    end else begin
      tx_insert_taken <= wait_load && cnt == delay;
      cnt             <= (wait_load && cnt != delay) ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule
